// File: src/tsec_pkg.sv
// Shared constants and carrier types of the two-stage event controller
package tsec_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NLVL      = 16;
	localparam int NGP       = 9;
	localparam int GP_BASE   = 7;
	localparam int NSRC_DEF  = 56;
	localparam int SRC_PER_W = 8;
	localparam int NASG_W    = 7;
	// ----------------------------------------
	// Core levels
	// ----------------------------------------
	localparam logic [3:0] LVL_EMU = 4'h0;
	localparam logic [3:0] LVL_RST = 4'h1;
	localparam logic [3:0] LVL_NMI = 4'h2;
	localparam logic [3:0] LVL_EXC = 4'h3;
	localparam logic [3:0] LVL_RSV = 4'h4;
	localparam logic [3:0] LVL_HWE = 4'h5;
	localparam logic [3:0] LVL_TMR = 4'h6;
	localparam logic [15:0] LATCH_RST = 16'h0002;
	localparam logic [15:0] FIXED_UNMASK = 16'h000F;
	localparam logic [15:0] CMASK_RST = 16'h0000;
	// ----------------------------------------
	// Register word addresses
	// ----------------------------------------
	localparam logic [7:0] A_ASSIGN0 = 8'h00;
	localparam logic [7:0] A_MASK0   = 8'h20;
	localparam logic [7:0] A_MASK1   = 8'h24;
	localparam logic [7:0] A_STAT0   = 8'h28;
	localparam logic [7:0] A_STAT1   = 8'h2C;
	localparam logic [7:0] A_WAKE0   = 8'h30;
	localparam logic [7:0] A_WAKE1   = 8'h34;
	localparam logic [7:0] A_CMASK   = 8'h38;
	localparam logic [7:0] A_PEND    = 8'h3C;
	localparam logic [7:0] A_LATCH   = 8'h40;
	localparam logic [7:0] A_SWRAISE = 8'h44;
	localparam logic [7:0] A_EVSTAT  = 8'h48;
	localparam logic [7:0] A_EVCLR   = 8'h4C;
	localparam logic [7:0] A_EVEN    = 8'h50;
	localparam int EV_TAKE = 0;
	localparam int EV_NEST = 1;
	localparam int EV_EMU  = 2;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} tsec_bus_t;
	typedef struct packed {
		logic       take;
		logic       ret;
		logic [3:0] level;
	} tsec_evt_t;
endpackage : tsec_pkg

// File: src/tsec_top.sv
// Two-stage event controller: peripheral routing stage and core priority stage
`timescale 1ns/1ps
// Functional notes
// RULE1: Registers reachable only in supervisor mode; otherwise they read zero, ignore writes.
// RULE2: Sixteen levels, 0 highest: emu, reset, NMI, exception, reserved, hwerr, timer, 7-15.
// RULE3: Nesting; a pending higher-priority event preempts any lower active one.
// RULE4: Emulation event puts the processor into emulation mode.
// RULE5: NMI raised by watchdog expiry or the external NMI pin.
// RULE6: Exceptions are synchronous, from alignment faults and undefined instructions.
// RULE7: Interrupts come from inputs, timers, peripherals and a software raise.
// RULE8: Each level keeps its own return address; entry signals a state save.
// RULE9: Nine general-purpose levels, 7 through 15.
// RULE10: Each peripheral source routes to a level chosen by writable assignment registers.
// RULE11: After reset sources 0-13 map to code 0; 10 and 11 reserved.
// RULE12: After reset sources 14-15 map to code 1, 16-19 to code 2.
// RULE13: After reset sources 20-25 map to code 3; code is level minus seven.
// RULE14: Each assignment register covers eight consecutive sources.
// RULE15: Set mask bit unmasks a source; cleared bit blocks it.
// RULE16: Status bits read one while the peripheral asserts its interrupt.
// RULE17: Wakeup-enable bit lets the source wake the core.
// RULE18: Pending-nesting state acknowledges sources on a shared level.
// RULE19: Unmasked sources on one level are ORed into that level's request.
module tsec_top import tsec_pkg::*; #(
	parameter int NSRC = NSRC_DEF,
	parameter int AW   = 32
) (
	input  wire logic            clock,
	input  wire logic            rst_b,
	input  wire tsec_bus_t       bus,
	input  wire logic            supervisor,
	output logic      [31:0]     rdata,
	input  wire logic [NSRC-1:0] periph_irq,
	input  wire logic            nmi_pin,
	input  wire logic            wdog_expire,
	input  wire logic            emu_req,
	input  wire logic            exc_req,
	input  wire logic            hw_err,
	input  wire logic            core_timer,
	input  wire logic            ret_strobe,
	input  wire logic [AW-1:0]   cur_pc,
	output tsec_evt_t            event_vector_table,
	output logic      [AW-1:0]   ret_addr,
	output logic      [15:0]     pending_nesting,
	output logic                 emulation_mode,
	output logic                 wake,
	output logic                 irq
);
	// ----------------------------------------
	// Default routing
	// ----------------------------------------
	function automatic logic [3:0] dflt_code(input int id);
		if (id <= 13) return 4'h0;
		else if (id <= 15) return 4'h1;
		else if (id <= 19) return 4'h2;
		else if (id <= 25) return 4'h3;
		else if (id <= 31) return 4'h4;
		else if (id <= 41) return 4'h5;
		else if (id <= 46) return 4'h6;
		else if (id <= 50) return 4'h0;
		else return 4'h3;
	endfunction : dflt_code

	function automatic logic [4:0] first_set(input logic [15:0] v);
		first_set = 5'h10;
		for (int k = NLVL - 1; k >= 0; k--) begin
			if (v[k]) first_set = 5'(k);
		end
	endfunction : first_set

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [NSRC-1:0] pirq_s1_r, pirq_s2_r;
	logic            nmi_s1_r, nmi_s2_r;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pirq_s1_r <= '0;
			pirq_s2_r <= '0;
			nmi_s1_r  <= 1'b0;
			nmi_s2_r  <= 1'b0;
		end else begin
			pirq_s1_r <= periph_irq;
			pirq_s2_r <= pirq_s1_r;
			nmi_s1_r  <= nmi_pin;
			nmi_s2_r  <= nmi_s1_r;
		end
	end

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	logic [NSRC-1:0] mask_r, wake_en_r;
	logic [3:0]      asg_r [NSRC];
	logic [15:0]     cmask_r, latch_r, pend_r;
	logic [2:0]      evstat_r, even_r;
	logic [63:0]     mask_w, stat_w, wake_w;
	wire wr_ok = bus.wr && supervisor; // RULE1
	wire rd_ok = bus.rd && supervisor; // RULE1
	wire wr_mask0 = wr_ok && bus.addr == A_MASK0;
	wire wr_mask1 = wr_ok && bus.addr == A_MASK1;
	wire wr_wake0 = wr_ok && bus.addr == A_WAKE0;
	wire wr_wake1 = wr_ok && bus.addr == A_WAKE1;
	wire wr_cmask = wr_ok && bus.addr == A_CMASK;
	wire wr_swr   = wr_ok && bus.addr == A_SWRAISE;
	wire wr_evclr = wr_ok && bus.addr == A_EVCLR;
	wire wr_even  = wr_ok && bus.addr == A_EVEN;
	assign mask_w = 64'(mask_r);
	assign stat_w = 64'(pirq_s2_r);
	assign wake_w = 64'(wake_en_r);

	// Source mask, wake enable
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			mask_r    <= '0;
			wake_en_r <= '0;
		end else begin
			if (wr_mask0 || wr_mask1) mask_r <= NSRC'({wr_mask1 ? bus.wdata : mask_w[63:32],
				wr_mask0 ? bus.wdata : mask_w[31:0]});
			if (wr_wake0 || wr_wake1) wake_en_r <= NSRC'({wr_wake1 ? bus.wdata : wake_w[63:32],
				wr_wake0 ? bus.wdata : wake_w[31:0]});
		end
	end

	// ----------------------------------------
	// Routing stage
	// ----------------------------------------
	for (genvar i = 0; i < NSRC; i++) begin : g_asg
		localparam logic [7:0] AOFF = A_ASSIGN0 + 8'((i / SRC_PER_W) * 4);
		wire wr_this = wr_ok && bus.addr == AOFF; // RULE14
		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b) asg_r[i] <= dflt_code(i); // RULE11 RULE12 RULE13
			else if (wr_this) asg_r[i] <= bus.wdata[4*(i%SRC_PER_W) +: 4]; // RULE10
		end
	end

	wire [NSRC-1:0] src_act = pirq_s2_r & mask_r; // RULE15
	logic [NGP-1:0] gp_req;
	always_comb begin
		gp_req = '0;
		for (int s = 0; s < NSRC; s++) begin
			for (int g = 0; g < NGP; g++) begin
				if (src_act[s] && asg_r[s] == 4'(g)) gp_req[g] = 1'b1; // RULE19 RULE10
			end
		end
	end
	assign wake = |(pirq_s2_r & wake_en_r); // RULE17

	// ----------------------------------------
	// Core stage
	// ----------------------------------------
	logic [15:0] raw_req, eff_mask, cand;
	logic [4:0]  cand_idx, cur_idx;
	assign raw_req = {gp_req, core_timer, hw_err, 1'b0, exc_req, // RULE2 RULE6 RULE9
		nmi_s2_r | wdog_expire, 1'b0, emu_req}; // RULE5 RULE4
	assign eff_mask = cmask_r | FIXED_UNMASK;
	assign cand     = latch_r & eff_mask;
	assign cand_idx = first_set(cand);
	assign cur_idx  = first_set(pend_r);
	wire take  = !ret_strobe && cand_idx < cur_idx; // RULE3
	wire ret   = ret_strobe && cur_idx != 5'h10;
	wire [15:0] take_oh = take ? 16'h0001 << cand_idx[3:0] : 16'h0000;
	wire [15:0] ret_oh  = ret ? 16'h0001 << cur_idx[3:0] : 16'h0000;
	wire [15:0] swr_set = wr_swr ? {bus.wdata[15:7], 7'h00} : 16'h0000; // RULE7
	// Shared levels relatch from hardware requests only once their pending bit drops; a software raise sets them at any time
	wire [15:0] hw_set = raw_req & ~{pend_r[15:7] | take_oh[15:7], 7'h00}; // RULE18

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			latch_r <= LATCH_RST;
			pend_r  <= '0;
			cmask_r <= CMASK_RST;
		end else begin
			latch_r <= ((latch_r & ~take_oh) | hw_set | swr_set) & ~16'(1 << LVL_RSV);
			pend_r  <= (pend_r | take_oh) & ~ret_oh; // RULE3
			if (wr_cmask) cmask_r <= bus.wdata[15:0];
		end
	end
	assign pending_nesting = pend_r;

	// Return address per level
	logic [AW-1:0] raddr_r [NLVL];
	for (genvar l = 0; l < NLVL; l++) begin : g_raddr
		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b) raddr_r[l] <= '0;
			else if (take_oh[l]) raddr_r[l] <= cur_pc; // RULE8
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			event_vector_table            <= '0;
			ret_addr       <= '0;
			emulation_mode <= 1'b0;
		end else begin
			event_vector_table.take  <= take; // RULE8
			event_vector_table.ret   <= ret;
			event_vector_table.level <= take ? cand_idx[3:0] : cur_idx[3:0];
			if (ret) ret_addr <= raddr_r[cur_idx[3:0]]; // RULE8
			if (take_oh[LVL_EMU]) emulation_mode <= 1'b1; // RULE4
			else if (ret_oh[LVL_EMU]) emulation_mode <= 1'b0;
		end
	end

	// ----------------------------------------
	// Event status and interrupt
	// ----------------------------------------
	wire [2:0] ev_set = {take_oh[LVL_EMU], take && cur_idx != 5'h10, take};
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			evstat_r <= '0;
			even_r   <= '0;
		end else begin
			evstat_r <= (evstat_r & ~(wr_evclr ? bus.wdata[2:0] : 3'h0)) | ev_set;
			if (wr_even) even_r <= bus.wdata[2:0];
		end
	end
	assign irq = |(evstat_r & even_r);

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	logic [31:0] rd_mux, asg_word [NASG_W];
	for (genvar w = 0; w < NASG_W; w++) begin : g_aw
		for (genvar n = 0; n < SRC_PER_W; n++) begin : g_an
			if (w * SRC_PER_W + n < NSRC) begin : g_on
				assign asg_word[w][4*n +: 4] = asg_r[w*SRC_PER_W+n];
			end else begin : g_off
				assign asg_word[w][4*n +: 4] = 4'h0;
			end
		end
	end
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (bus.addr)
			A_MASK0:   rd_mux = mask_w[31:0];
			A_MASK1:   rd_mux = mask_w[63:32];
			A_STAT0:   rd_mux = stat_w[31:0]; // RULE16
			A_STAT1:   rd_mux = stat_w[63:32]; // RULE16
			A_WAKE0:   rd_mux = wake_w[31:0];
			A_WAKE1:   rd_mux = wake_w[63:32];
			A_CMASK:   rd_mux = {16'h0000, cmask_r};
			A_PEND:    rd_mux = {16'h0000, pend_r};
			A_LATCH:   rd_mux = {16'h0000, latch_r};
			A_EVSTAT:  rd_mux = {29'h0, evstat_r};
			A_EVEN:    rd_mux = {29'h0, even_r};
			default: begin
				if (bus.addr < 8'(NASG_W * 4) && bus.addr[1:0] == 2'b00)
					rd_mux = asg_word[bus.addr[4:2]];
			end
		endcase
	end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) rdata <= '0;
		else rdata <= rd_ok ? rd_mux : 32'h0000_0000; // RULE1
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_user_read_zero: assert property (bus.rd && !supervisor |=> rdata == 32'h0) // RULE1
		else $error("user-mode read returned data");
	a_take_higher: assert property (event_vector_table.take |-> // RULE2
		$past(pend_r) == 16'h0 || event_vector_table.level < $past(cur_idx[3:0]))
		else $error("taken event not above active level");
	a_preempt_bound: assert property (cand_idx < cur_idx && !ret_strobe |=> // RULE3
		event_vector_table.take && pend_r[$past(cand_idx[3:0])])
		else $error("higher event not taken next cycle");
	a_emu_mode: assert property (event_vector_table.take && event_vector_table.level == LVL_EMU |-> emulation_mode) // RULE4
		else $error("emulation mode not entered");
	a_nmi_latch: assert property (wdog_expire && !pend_r[LVL_NMI] |=> latch_r[LVL_NMI]
		|| pend_r[LVL_NMI]) // RULE5
		else $error("watchdog did not raise NMI");
	a_ret_addr: assert property (ret |=> ret_addr == $past(raddr_r[cur_idx[3:0]])) // RULE8
		else $error("wrong return address");
	a_mask_block: assert property (!(|mask_r) |-> gp_req == '0) // RULE15
		else $error("masked source reached a level");
	a_wake_src: assert property (wake |-> |($past(periph_irq, 2) & wake_en_r)) // RULE17
		else $error("wake without enabled source");
	a_swr_latch: assert property (wr_swr && bus.wdata[15] && !take_oh[15] |=> latch_r[15]) // RULE7
		else $error("software raise lost");
	a_rsv_never: assert property (!latch_r[LVL_RSV] && !pend_r[LVL_RSV]) // RULE2
		else $error("reserved level active");
	// Pending shared level stays unlatched until it drops, unless a software raise sets it
	a_shared_ack: assert property (!wr_swr |=> // RULE18
		(latch_r[15:7] & $past(pend_r[15:7] & ~latch_r[15:7])) == 9'h000)
		else $error("shared level relatched while pending");
	a_ret_clear: assert property (ret |=> !pend_r[$past(cur_idx[3:0])]) // RULE3
		else $error("returned level still pending");
	c_nested: cover property (event_vector_table.take ##[1:20] event_vector_table.take);
	c_emu: cover property (emulation_mode ##[1:50] !emulation_mode);
	c_gp_take: cover property (event_vector_table.take && event_vector_table.level > 4'h6);
	c_irq: cover property (irq);
endmodule : tsec_top

// File: testbench/tsec_seq_model.sv
// Sequencer model: enters taken events and returns from them after a hold
`timescale 1ns/1ps
module tsec_seq_model import tsec_pkg::*; (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire tsec_evt_t   event_vector_table,
	input  wire logic [15:0] pending_nesting,
	input  wire logic        slow,
	output logic             ret_strobe,
	output logic      [31:0] cur_pc
);
	logic [5:0] hold_r;
	// ----------------------------------------
	// Hold restarts on each take, so a preempting event is served first
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			hold_r     <= 6'h00;
			ret_strobe <= 1'b0;
			cur_pc     <= 32'h00001000;
		end else begin
			cur_pc     <= cur_pc + 32'h4;
			ret_strobe <= 1'b0;
			if (event_vector_table.take || ret_strobe)
				hold_r <= slow ? 6'h28 : 6'h06;
			else if (hold_r != 6'h00)
				hold_r <= hold_r - 6'h01;
			else if (pending_nesting != 16'h0000)
				ret_strobe <= 1'b1;
		end
	end
endmodule : tsec_seq_model

// File: testbench/tb.sv
// Self-checking bench of the two-stage event controller
`timescale 1ns/1ps
module tb import tsec_pkg::*;;
	logic             clock, rst_b, supervisor, nmi_pin, wdog_expire, emu_req;
	logic             exc_req, hw_err, core_timer, ret_strobe, slow, emulation_mode, wake, irq;
	tsec_bus_t        bus;
	tsec_evt_t        event_vector_table;
	logic      [31:0] rdata, cur_pc, ret_addr, pc_exp;
	logic      [55:0] periph_irq;
	logic      [15:0] pending_nesting;
	logic      [4:0]  creq;
	logic      [3:0]  lvls[5] = '{LVL_EMU, LVL_NMI, LVL_EXC, LVL_HWE, LVL_TMR};
	int               corner[6] = '{0, 13, 14, 15, 19, 25};
	int               err_total, n_checks, i, s, c;
	assign {core_timer, hw_err, exc_req, nmi_pin, emu_req} = creq;
	tsec_top dut (.clock(clock), .rst_b(rst_b), .bus(bus), .supervisor(supervisor),
		.rdata(rdata), .periph_irq(periph_irq), .nmi_pin(nmi_pin), .wdog_expire(wdog_expire),
		.emu_req(emu_req), .exc_req(exc_req), .hw_err(hw_err), .core_timer(core_timer),
		.ret_strobe(ret_strobe), .cur_pc(cur_pc), .event_vector_table(event_vector_table), .ret_addr(ret_addr),
		.pending_nesting(pending_nesting), .emulation_mode(emulation_mode), .wake(wake), .irq(irq));
	tsec_seq_model seq (.clock(clock), .rst_b(rst_b), .event_vector_table(event_vector_table),
		.pending_nesting(pending_nesting), .slow(slow), .ret_strobe(ret_strobe), .cur_pc(cur_pc));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		bus <= '0;
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge clock);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clock);
		bus <= '0;
		#1;
		chk(what, rdata, exp);
	endtask : rdchk
	task automatic wait_take(input logic [3:0] exp, input string what);
		int k;
		for (k = 0; k < 200; k++) begin
			@(posedge clock);
			#1;
			if (event_vector_table.take === 1'b1)
				break;
		end
		if (k == 200) begin
			err_total++;
			$display("ERROR %s expected take seen none", what);
			conclude();
		end
		chk(what, 32'(event_vector_table.level), 32'(exp));
	endtask : wait_take
	task automatic wait_idle();
		int k;
		for (k = 0; k < 300 && pending_nesting !== 16'h0000; k++)
			@(posedge clock);
		chk("idle", 32'(pending_nesting), 32'h0);
		if (k == 300)
			conclude();
	endtask : wait_idle
	task automatic no_take(input int n);
		repeat (n) begin
			@(posedge clock);
			#1;
			chk("blocked", 32'(event_vector_table.take), 32'h0);
		end
	endtask : no_take
	task automatic pirq(input int src, input logic [3:0] exp);
		@(posedge clock);
		periph_irq[src] <= 1'b1;
		wait_take(exp, "peripheral level");
		periph_irq <= '0;
		wait_idle();
	endtask : pirq
	function automatic logic [3:0] def_lvl(input int src);
		return (src < 14) ? 4'h7 : (src < 16) ? 4'h8 : (src < 20) ? 4'h9 : 4'hA;
	endfunction : def_lvl
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_b = 1'b0;
		bus = '0;
		supervisor = 1'b1;
		periph_irq = '0;
		creq = '0;
		wdog_expire = 1'b0;
		slow = 1'b0;
		void'($urandom(66));
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		wait_take(LVL_RST, "reset event");
		wait_idle();
		$display("test reset done");
		wr(A_CMASK, 32'h0000FFE0);
		wr(A_MASK0, 32'hFFFFFFFF);
		wr(A_MASK1, 32'h00FFFFFF);
		for (i = 0; i < 12; i++) begin
			s = (i < 6) ? corner[i] : $urandom_range(25, 0);
			pirq(s, def_lvl(s));
		end
		for (i = 0; i < 5; i++) begin
			s = (i == 0) ? 24 : $urandom_range(55, 0);
			c = $urandom_range(8, 0);
			wr(A_ASSIGN0 + 8'(4 * (s / 8)), 32'(c) << (4 * (s % 8)));
			pirq(s, 4'(7 + c));
		end
		$display("test routing done");
		wr(A_MASK0, 32'h0);
		wr(A_WAKE0, 32'h8);
		periph_irq[3] <= 1'b1;
		no_take(12);
		rdchk(A_STAT0, 32'h8, "status");
		chk("wake", 32'(wake), 32'h1);
		periph_irq[3] <= 1'b0;
		$display("test mask done");
		slow <= 1'b1;
		for (i = 0; i < 5; i++) begin
			@(posedge clock);
			creq <= 5'(1 << i);
			@(posedge clock);
			creq <= '0;
			wait_take(lvls[i], "core event");
			pc_exp = cur_pc - 32'h4;
			if (i == 0)
				chk("emulation", 32'(emulation_mode), 32'h1);
			wait_idle();
			chk("return address", ret_addr, pc_exp);
		end
		creq <= 5'h10;
		wait_take(LVL_TMR, "timer");
		wdog_expire <= 1'b1;
		creq <= '0;
		wait_take(LVL_NMI, "watchdog preempt");
		wdog_expire <= 1'b0;
		chk("nesting", 32'(pending_nesting), 32'h44);
		wait_idle();
		creq <= 5'h14;
		@(posedge clock);
		creq <= '0;
		wait_take(LVL_EXC, "first of two");
		wait_take(LVL_TMR, "second of two");
		wr(A_SWRAISE, 32'h4000);
		wait_take(4'hE, "software raise");
		wait_idle();
		$display("test core events done");
		supervisor <= 1'b0;
		rdchk(A_CMASK, 32'h0, "user read");
		wr(A_CMASK, 32'h0);
		supervisor <= 1'b1;
		rdchk(A_CMASK, 32'hFFE0, "user write");
		rdchk(8'h80, 32'h0, "unmapped");
		wr(A_EVEN, 32'h0);
		rdchk(A_EVSTAT, 32'h7, "event status");
		chk("irq masked", 32'(irq), 32'h0);
		wr(A_EVEN, 32'h7);
		#1;
		chk("irq raised", 32'(irq), 32'h1);
		wr(A_EVCLR, 32'h7);
		rdchk(A_EVSTAT, 32'h0, "event cleared");
		chk("irq cleared", 32'(irq), 32'h0);
		$display("test registers done");
		conclude();
	end
endmodule : tb
